// file: include/ssp_defines.svh
// Purpose: Named constants of the serial shift port control block
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_IDX_DATA  12'h060
`define SSP_IDX_CTRL  12'h062
`define SSP_IDX_STAT  12'h064
`define SSP_AW        12
`define SSP_CTRL_RST  16'h0000
`define SSP_OVR_BIT   2
`define SSP_TOG8      6'h10
`define SSP_TOG16     6'h20
`define SSP_SMP8      6'h08
`define SSP_SMP16     6'h10
`define SSP_DIV0      7'h00
`endif

// file: include/ssp_pkg.sv
// Purpose: Types of the serial shift port control block
// Assumes: Constants live in ssp_defines.svh
// Notes:   Control word layout mirrors the 16-bit register
package ssp_pkg;
   typedef struct packed {
      logic [6:0] clock_divider;
      logic       clock_idle_level;
      logic       clock_edge_select;
      logic       tx_done_irq_enable;
      logic       rx_full_irq_enable;
      logic       overrun_irq_enable;
      logic       echo_enable;
      logic       word_size_select;
      logic       master_select;
      logic       port_enable;
   } ctrl_t;
   typedef struct packed {
      logic shift_clock;
      logic master_in_slave_out;
      logic master_out_slave_in;
      logic slave_select_n;
   } pin_in_t;
   typedef struct packed {
      logic shift_clock;
      logic shift_clock_oe;
      logic master_in_slave_out;
      logic master_in_slave_out_oe;
      logic master_out_slave_in;
      logic master_out_slave_in_oe;
   } pin_out_t;
   typedef struct packed {
      ctrl_t       ctrl;
      logic [15:0] shifter;
      logic [15:0] rdbuf;
      logic        busy;
      logic        rx_buffer_full;
      logic        rx_overrun;
      logic        tx_valid;
      logic        shf_full;
      logic        active;
      logic [5:0]  edges;
      logic [6:0]  divcnt;
      logic        sck_prev;
      logic        last_in;
      pin_out_t    pins;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } state_t;
endpackage : ssp_pkg

// file: rtl/serial_shift_port_control.sv
// Purpose: Control logic and shifter of a three-wire serial port
// Assumes: APB slave, pins synchronous to pclk
// Notes:   One word registers: data, control, status
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module serial_shift_port_control (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`SSP_AW-1:0]    paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire ssp_pkg::pin_in_t      pins_in,
   output ssp_pkg::pin_out_t          pins_out,
   output logic                       irq
);
   import ssp_pkg::*;

   state_t r;
   state_t next_r;

   logic [`SSP_AW-1:0] a_data;
   logic [`SSP_AW-1:0] a_ctrl;
   logic [`SSP_AW-1:0] a_stat;
   logic               setup;
   logic               acc;
   logic               master;
   logic               en;
   logic               launch_lead;
   logic [15:0]        sh_new;
   logic               rise;
   logic               lvl;
   logic               cs;

   // Byte addresses are four times the register index
   assign a_data = `SSP_IDX_DATA << 2;
   assign a_ctrl = `SSP_IDX_CTRL << 2;
   assign a_stat = `SSP_IDX_STAT << 2;
   assign setup  = psel & ~penable;
   assign acc    = psel & penable & r.pready;
   assign master = r.ctrl.master_select;
   assign en     = r.ctrl.port_enable;
   // launch on leading edge when mode and idle differ
   assign launch_lead = r.ctrl.clock_edge_select ^ r.ctrl.clock_idle_level;

   // Outputs come straight from state flops
   assign prdata   = r.prdata;
   assign pready   = r.pready;
   assign pslverr  = r.pslverr;
   assign pins_out = r.pins;
   assign irq      = r.irq;

   // top bit of the selected word size
   function automatic logic top_bit(input logic [15:0] d, input logic w16);
      top_bit = w16 ? d[15] : d[7];
   endfunction : top_bit

   // Next state: bus access, shifting, flags, pins
   always_comb begin
      next_r         = r;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      sh_new         = r.shifter;
      rise           = 1'b0;
      lvl            = 1'b0;
      cs             = ~pins_in.slave_select_n;
      next_r.irq     = 1'b0;
      // Read data is latched in setup so the access cycle answers
      if (setup) begin
         next_r.pready = 1'b1;
         next_r.prdata = 32'h0000_0000;
         if (paddr == a_data) begin
            next_r.prdata[15:0] = r.rdbuf;
         end else if (paddr == a_ctrl) begin
            next_r.prdata[15:0] = r.ctrl;
         end else if (paddr == a_stat) begin
            next_r.prdata[2:0] = {r.rx_overrun, r.rx_buffer_full, r.busy};
         end else begin
            next_r.pslverr = 1'b1;
         end
      end
      // Software side effects come first so hardware sets win
      if (acc && pwrite) begin
         if (paddr == a_ctrl) begin
            next_r.ctrl = ctrl_t'(pwdata[15:0]);
         end else if (paddr == a_stat && pwdata[`SSP_OVR_BIT]) begin
            next_r.rx_overrun = 1'b0;
         end else if (paddr == a_data && en && (!r.busy || r.shf_full)) begin
            next_r.shifter  = pwdata[15:0];
            next_r.tx_valid = 1'b1;
            if (master) begin
               // Overrun: buffer and shifter full, new transfer begins
               if (r.shf_full && r.rx_buffer_full) begin
                  next_r.rx_overrun = 1'b1;
               end
               next_r.shf_full = 1'b0;
               next_r.busy     = 1'b1;
               next_r.active   = 1'b1;
               next_r.edges    = 6'h00;
               next_r.divcnt   = `SSP_DIV0;
               if (!launch_lead) begin
                  next_r.pins.master_out_slave_in =
                     top_bit(pwdata[15:0], r.ctrl.word_size_select);
               end
            end
         end
      end
      // Reading data frees the buffer or moves a held word in
      if (acc && !pwrite && paddr == a_data) begin
         if (r.shf_full) begin
            next_r.rdbuf    = r.ctrl.word_size_select ? r.shifter
                                 : {r.rdbuf[15:8], r.shifter[7:0]};
            next_r.shf_full = 1'b0;
            next_r.busy     = 1'b0;
         end else begin
            next_r.rx_buffer_full = 1'b0;
         end
      end
      // Master pins: idle level when not shifting
      if (master) begin
         next_r.pins.shift_clock_oe         = 1'b1;
         next_r.pins.master_out_slave_in_oe = 1'b1;
         next_r.pins.master_in_slave_out_oe = 1'b0;
         // An aborted transfer must not leave the clock parked mid-period
         if (!r.active || !en) begin
            next_r.pins.shift_clock = r.ctrl.clock_idle_level;
         end
      end else begin
         // slave drives only its data output while selected
         next_r.pins.shift_clock_oe         = 1'b0;
         next_r.pins.master_out_slave_in_oe = 1'b0;
         next_r.pins.master_in_slave_out_oe = en & cs;
      end
      // Master shifting
      if (en && master && r.active) begin
         if (r.divcnt == r.ctrl.clock_divider) begin
            // half period is divider plus one cycles
            next_r.divcnt = `SSP_DIV0;
            rise          = ~r.pins.shift_clock;
            next_r.pins.shift_clock = rise;
            next_r.edges  = r.edges + 6'h01;
            // sample or launch by edge and mode
            if (rise ^ r.ctrl.clock_edge_select) begin
               sh_new = {r.shifter[14:0], pins_in.master_in_slave_out};
               next_r.shifter = sh_new;
            end else begin
               next_r.pins.master_out_slave_in =
                  top_bit(r.shifter, r.ctrl.word_size_select);
            end
            // stop after 8 or 16 full clocks
            if (next_r.edges == (r.ctrl.word_size_select ? `SSP_TOG16 : `SSP_TOG8)) begin
               next_r.active   = 1'b0;
               next_r.tx_valid = 1'b0;
               if (!next_r.rx_buffer_full) begin
                  next_r.rdbuf = r.ctrl.word_size_select ? sh_new
                                    : {r.rdbuf[15:8], sh_new[7:0]};
                  next_r.rx_buffer_full   = 1'b1;
                  next_r.busy  = 1'b0;
               end else begin
                  next_r.shf_full = 1'b1;
               end
            end
         end else begin
            next_r.divcnt = r.divcnt + 7'h01;
         end
      end
      // Slave shifting on the sampled external clock
      next_r.sck_prev = pins_in.shift_clock;
      if (en && !master) begin
         if (!cs) begin
            // Deselect resynchronises the bit count
            next_r.active = 1'b0;
            next_r.edges  = 6'h00;
            if (r.active && !r.shf_full) begin
               next_r.busy = 1'b0;
            end
         end else if (pins_in.shift_clock != r.sck_prev) begin
            lvl  = pins_in.shift_clock;
            rise = lvl;
            if (lvl != r.ctrl.clock_idle_level && !r.active) begin
               next_r.active = 1'b1;
               next_r.busy   = 1'b1;
               next_r.edges  = 6'h00;
            end
            if (rise ^ r.ctrl.clock_edge_select) begin
               sh_new = {r.shifter[14:0], pins_in.master_out_slave_in};
               next_r.shifter = sh_new;
               next_r.last_in = pins_in.master_out_slave_in;
               next_r.edges   = r.edges + 6'h01;
               if (r.edges + 6'h01 ==
                   (r.ctrl.word_size_select ? `SSP_SMP16 : `SSP_SMP8)) begin
                  next_r.active   = 1'b0;
                  next_r.edges    = 6'h00;
                  next_r.tx_valid = 1'b0;
                  if (!next_r.rx_buffer_full) begin
                     next_r.rdbuf = r.ctrl.word_size_select ? sh_new
                                       : {r.rdbuf[15:8], sh_new[7:0]};
                     next_r.rx_buffer_full   = 1'b1;
                     next_r.busy  = 1'b0;
                  end else begin
                     next_r.shf_full = 1'b1;
                  end
               end
            end else begin
               // echo only in slave mode without valid data
               next_r.pins.master_in_slave_out =
                  (r.ctrl.echo_enable && !r.tx_valid) ? r.last_in
                  : top_bit(r.shifter, r.ctrl.word_size_select);
            end
         end else if (!r.active && !launch_lead) begin
            // First bit waits on the line before the first clock
            next_r.pins.master_in_slave_out =
               top_bit(r.shifter, r.ctrl.word_size_select);
         end
      end
      if (!en) begin
         next_r.busy     = 1'b0;
         next_r.rx_buffer_full      = 1'b0;
         next_r.rx_overrun      = 1'b0;
         next_r.shf_full = 1'b0;
         next_r.active   = 1'b0;
         next_r.edges    = 6'h00;
         next_r.divcnt   = `SSP_DIV0;
         next_r.tx_valid = 1'b0; // Disable ends the transfer, so data is stale
         next_r.pins.master_out_slave_in = 1'b0;
      end
      next_r.irq = en & ((r.ctrl.overrun_irq_enable & r.rx_overrun)
                       | (r.ctrl.rx_full_irq_enable & r.rx_buffer_full)
                       | (r.ctrl.tx_done_irq_enable & ~r.busy));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r      <= '0;
         r.ctrl <= ctrl_t'(`SSP_CTRL_RST);
      end else begin
         r <= next_r;
      end
   end

   // Disabled port shows no flags
   property p_dis_flags;
      @(posedge pclk) disable iff (!presetn)
      !en |=> !r.busy && !r.rx_buffer_full && !r.rx_overrun;
   endproperty
   a_dis_flags: assert property (p_dis_flags) else $error("flags set while disabled");

   property p_dis_master;
      @(posedge pclk) disable iff (!presetn)
      !en && master |=> r.pins.shift_clock == $past(r.ctrl.clock_idle_level)
         && r.pins.shift_clock_oe && r.pins.master_out_slave_in_oe
         && !r.pins.master_in_slave_out_oe;
   endproperty
   a_dis_master: assert property (p_dis_master) else $error("disabled master pins wrong");

   property p_dis_slave;
      @(posedge pclk) disable iff (!presetn)
      !en && !master |=> !r.pins.shift_clock_oe && !r.pins.master_in_slave_out_oe
         && !r.pins.master_out_slave_in_oe;
   endproperty
   a_dis_slave: assert property (p_dis_slave) else $error("disabled slave drives");

   property p_ctrl_read;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == a_ctrl |=> pready && prdata == {16'h0000, $past(r.ctrl)};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

   property p_irq_ovr;
      @(posedge pclk) disable iff (!presetn)
      en && r.rx_overrun && r.ctrl.overrun_irq_enable |=> irq;
   endproperty
   a_irq_ovr: assert property (p_irq_ovr) else $error("overrun irq missing");

   property p_irq_rbf;
      @(posedge pclk) disable iff (!presetn)
      en && r.rx_buffer_full && r.ctrl.rx_full_irq_enable |=> irq;
   endproperty
   a_irq_rbf: assert property (p_irq_rbf) else $error("read irq missing");

   property p_irq_none;
      @(posedge pclk) disable iff (!presetn)
      !r.ctrl.tx_done_irq_enable && !r.ctrl.rx_full_irq_enable
         && !r.ctrl.overrun_irq_enable |=> !irq;
   endproperty
   a_irq_none: assert property (p_irq_none) else $error("spurious irq");

   property p_count;
      @(posedge pclk) disable iff (!presetn)
      $fell(r.active) && en && master |->
         r.edges == (r.ctrl.word_size_select ? `SSP_TOG16 : `SSP_TOG8);
   endproperty
   a_count: assert property (p_count) else $error("wrong clock count");

   property p_div;
      @(posedge pclk) disable iff (!presetn)
      en && master && r.active && $changed(r.pins.shift_clock) && $past(r.active)
         |-> $past(r.divcnt) == r.ctrl.clock_divider;
   endproperty
   a_div: assert property (p_div) else $error("divider period wrong");

   property p_slave_tx;
      @(posedge pclk) disable iff (!presetn)
      acc && pwrite && paddr == a_data && en && !master && !r.busy |=> r.tx_valid;
   endproperty
   a_slave_tx: assert property (p_slave_tx) else $error("data not marked valid");

   c_master_done: cover property (@(posedge pclk) disable iff (!presetn)
      en && master && $fell(r.active));
   c_slave_done: cover property (@(posedge pclk) disable iff (!presetn)
      en && !master && $rose(r.rx_buffer_full));
   c_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.rx_overrun));
   c_echo: cover property (@(posedge pclk) disable iff (!presetn)
      en && !master && r.ctrl.echo_enable && r.active && !r.tx_valid);
endmodule : serial_shift_port_control
`default_nettype wire

// file: verif/ssp_far_side.sv
// Purpose: Far-side serial peer of the port, slave or master
// Assumes: Pins move on pclk; master half period is HALF cycles
// Notes:   A released line flips every cycle instead of holding
`timescale 1ns/1ps
`default_nettype none
module ssp_far_side #(
   parameter int HALF = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire ssp_pkg::pin_out_t pins_out,
   input  wire logic              dut_master,
   input  wire logic              alt,
   input  wire logic              word16,
   input  wire logic              go,
   input  wire logic [15:0]       tx_word,
   output ssp_pkg::pin_in_t       pins_in,
   output logic [15:0]            rx_word,
   output logic                   run
);
   import ssp_pkg::*;
   logic [15:0] sh;
   logic [5:0]  tog;
   logic [7:0]  cnt;
   logic        sck;
   logic        ss_n;
   logic [2:0]  last;
   logic        sck_w;
   logic        miso_w;
   logic        mosi_w;
   // Wire levels; undriven lines never show a stale copy
   assign sck_w = !dut_master ? sck : pins_out.shift_clock_oe ?
                  pins_out.shift_clock : ~last[2];
   assign mosi_w = !dut_master ? sh[15] : pins_out.master_out_slave_in_oe ?
                   pins_out.master_out_slave_in : ~last[1];
   assign miso_w = dut_master ? sh[15] : pins_out.master_in_slave_out_oe ?
                   pins_out.master_in_slave_out : ~last[0];
   assign pins_in = {sck_w, miso_w, mosi_w, ss_n | dut_master};
   // With the port as master, shifting right after a sample edge keeps the next bit ready early; as master the peer shifts on the other edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh      <= 16'h0000;
         rx_word <= 16'h0000;
         run     <= 1'b0;
         sck     <= 1'b0;
         ss_n    <= 1'b1;
         cnt     <= 8'h00;
         tog     <= 6'h00;
         last    <= 3'h0;
      end else begin
         last <= {sck_w, mosi_w, miso_w};
         if (go) begin
            sh      <= word16 ? tx_word : {tx_word[7:0], 8'h00};
            rx_word <= 16'h0000;
            run     <= !dut_master;
            ss_n    <= dut_master;
            cnt     <= 8'h00;
            tog     <= 6'h00;
         end else if (dut_master && sck_w != last[2] && sck_w == !alt) begin
            rx_word <= {rx_word[14:0], mosi_w};
            sh      <= sh << 1;
         end else if (run) begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(HALF - 1)) begin
               cnt <= 8'h00;
               if (tog == (word16 ? 6'h20 : 6'h10)) begin
                  run  <= 1'b0;
                  ss_n <= 1'b1;
               end else begin
                  sck <= ~sck;
                  tog <= tog + 6'h01;
                  if (!sck)
                     rx_word <= {rx_word[14:0], miso_w};
                  else
                     sh <= sh << 1;
               end
            end
         end
      end
   end
endmodule : ssp_far_side
`default_nettype wire

// file: verif/serial_shift_port_control_tb.sv
// Purpose: Self-checking bench of the serial shift port control
// Assumes: APB answer waited for; peer half period of 4 cycles
// Notes:   Random words from a fixed seed beside corner cases
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module serial_shift_port_control_tb;
   import ssp_pkg::*;
   localparam logic [11:0] DAT = `SSP_IDX_DATA << 2;
   localparam logic [11:0] CTL = `SSP_IDX_CTRL << 2;
   localparam logic [11:0] STA = `SSP_IDX_STAT << 2;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   pin_in_t     pins_in;
   pin_out_t    pins_out;
   logic        dut_master = 1'b0;
   logic        alt = 1'b0;
   logic        word16 = 1'b0;
   logic        go = 1'b0;
   logic [15:0] tx_word = 16'h0;
   logic [15:0] rx_word;
   logic        run;
   logic [15:0] rdexp = 16'h0;
   logic [31:0] q;
   logic        err;
   int          err_total = 0;
   int          check_count = 0;
   always #2 pclk = ~pclk;
   serial_shift_port_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
      .pins_out(pins_out), .irq(irq));
   ssp_far_side far (.pclk(pclk), .presetn(presetn), .pins_out(pins_out),
      .dut_master(dut_master), .alt(alt), .word16(word16), .go(go),
      .tx_word(tx_word), .pins_in(pins_in), .rx_word(rx_word), .run(run));
   // Read buffer after a word; 8-bit mode leaves the upper byte alone
   function automatic logic [15:0] exp_rd(logic [15:0] p, logic [15:0] t, logic w16);
      return w16 ? t : {p[15:8], t[7:0]};
   endfunction : exp_rd
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   // One APB transfer; the answer is taken at the rising edge that sees pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Values read right after the edge are the ones sampled at it
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHECK(q, e)
   endtask : rd_chk
   // Fields are changed only while the port is held disabled
   task automatic setup(input logic [15:0] c);
      apb(1'b0, CTL, 32'h0);
      apb(1'b1, CTL, {16'h0, q[15:1], 1'b0});
      dut_master <= c[1];
      alt        <= c[7];
      word16     <= c[2];
      apb(1'b1, CTL, {16'h0, c[15:1], 1'b0});
      apb(1'b1, CTL, {16'h0, c[15:1], 1'b1});
   endtask : setup
   task automatic shift(input logic [15:0] c, input logic [15:0] w);
      int n, h, tg, f, l;
      logic s;
      logic [15:0] t, m;
      n = c[2] ? 16 : 8;
      h = c[15:9] + 1;
      m = c[2] ? 16'hFFFF : 16'h00FF;
      t = 16'($urandom);
      tx_word <= t;
      go      <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      apb(1'b1, DAT, {16'h0, w});
      s  = c[8];
      tg = 0;
      for (int i = 0; i < (2 * n + 4) * h; i++) begin
         @(negedge pclk);
         if (pins_out.shift_clock !== s) begin
            tg++;
            if (tg == 1)
               f = i;
            l = i;
            s = pins_out.shift_clock;
         end
      end
      `CHECK(tg, 2 * n)
      `CHECK(l - f, (2 * n - 1) * h)
      `CHECK(pins_out.shift_clock, c[8])
      `CHECK(rx_word & m, w & m)
      rdexp = exp_rd(rdexp, t, c[2]);
   endtask : shift
   task automatic slave_run(input logic [15:0] w);
      int k;
      k = 0;
      tx_word <= w;
      go      <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do @(negedge pclk); while (run === 1'b1 && ++k < 300);
      if (k >= 300) begin
         err_total++;
         close_out();
      end
   endtask : slave_run
   initial begin
      logic [15:0] c, w, d;
      c = 16'($urandom(32'hDF71A653));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(CTL, 32'h0);
      rd_chk(STA, 32'h0);
      `CHECK({pins_out.shift_clock_oe, pins_out.master_in_slave_out_oe}, 2'b00)
      `CHECK(irq, 1'b0)
      apb(1'b0, 12'h1A0, 32'h0);
      `CHECK({err, q}, 33'h100000000)
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         c = 16'($urandom) & 16'hFFFE;
         apb(1'b1, CTL, {16'($urandom), c});
         rd_chk(CTL, {16'h0, c});
      end
      $display("test registers done");
      apb(1'b1, CTL, 32'h0102);
      repeat (2) @(negedge pclk);
      `CHECK({pins_out.shift_clock, pins_out.shift_clock_oe}, 2'b11)
      `CHECK({pins_out.master_out_slave_in, pins_out.master_out_slave_in_oe}, 2'b01)
      `CHECK(pins_out.master_in_slave_out_oe, 1'b0)
      apb(1'b1, DAT, 32'h5A5A);
      rd_chk(STA, 32'h0);
      $display("test disabled pins done");
      for (int i = 0; i < 6; i++) begin
         c = {7'($urandom_range(3, 1)), 1'($urandom), 1'($urandom), 3'h0,
              1'($urandom), 1'($urandom), 2'b10};
         if (i == 0)
            c = 16'h0202;
         if (i == 1)
            c = 16'hFE8E;
         setup(c);
         shift(c, 16'($urandom));
         rd_chk(STA, 32'h2);
         rd_chk(DAT, {16'h0, rdexp});
         rd_chk(STA, 32'h0);
      end
      $display("test master done");
      setup(16'h0222);
      shift(16'h0222, 16'hC3A5);
      `CHECK(irq, 1'b1)
      rd_chk(DAT, {16'h0, rdexp});
      repeat (2) @(negedge pclk);
      `CHECK(irq, 1'b0)
      setup(16'h0242);
      repeat (2) @(negedge pclk);
      `CHECK(irq, 1'b1)
      apb(1'b1, DAT, 32'h0F0F);
      repeat (2) @(negedge pclk);
      `CHECK(irq, 1'b0)
      repeat (40) @(negedge pclk);
      `CHECK(irq, 1'b1)
      $display("test interrupts done");
      setup(16'h0212);
      shift(16'h0212, 16'h0011);
      shift(16'h0212, 16'h0022);
      rd_chk(STA, 32'h3);
      `CHECK(irq, 1'b0)
      apb(1'b1, DAT, 32'h0033);
      repeat (2) @(negedge pclk);
      `CHECK(irq, 1'b1)
      apb(1'b0, STA, 32'h0);
      `CHECK(q[2], 1'b1)
      apb(1'b1, STA, 32'h4);
      rd_chk(STA, 32'h3);
      apb(1'b1, CTL, 32'h0212);
      rd_chk(STA, 32'h0);
      $display("test overrun done");
      dut_master <= 1'b0;
      apb(1'b1, CTL, 32'h0008);
      apb(1'b1, CTL, 32'h0009);
      w = 16'($urandom);
      slave_run(w);
      `CHECK(rx_word[6:0], w[7:1])
      rd_chk(STA, 32'h2);
      apb(1'b0, DAT, 32'h0);
      `CHECK(q[7:0], w[7:0])
      apb(1'b1, CTL, 32'h0008);
      apb(1'b1, CTL, 32'h0000);
      apb(1'b1, CTL, 32'h0001);
      d = 16'($urandom);
      apb(1'b1, DAT, {16'h0, d});
      slave_run(w);
      `CHECK(rx_word[7:0], d[7:0])
      $display("test slave done");
      close_out();
   end
endmodule : serial_shift_port_control_tb
`default_nettype wire
